// file: common/usi_params.svh
// Offsets, field positions, reset values and counts of the serial status block
`ifndef USI_PARAMS_SVH
`define USI_PARAMS_SVH

// ==========================================
// Register offsets (byte addresses)
`define USI_OFF_STATUS 8'h04
`define USI_OFF_IRQ_EN 8'h08
`define USI_OFF_IRQ_FL 8'h0c

// ==========================================
// Event bit positions, shared by enable and flags
`define USI_BIT_RX_FERR 0
`define USI_BIT_RX_PAR 1
`define USI_BIT_CLEAR_TO_SEND_CHANGE_EVENT 2
`define USI_BIT_RX_OVERRUN_EVENT 3
`define USI_BIT_RX_THD 4
`define USI_BIT_TX_HALF_EMPTY_EVENT 6
`define USI_IRQ_IMPL_MASK 7'h5f

// ==========================================
// Status word bit positions
`define USI_ST_TX_BUSY 0
`define USI_ST_RX_BUSY 1
`define USI_ST_RX_EMPTY 4
`define USI_ST_RX_FULL 5
`define USI_ST_TX_EMPTY 6
`define USI_ST_TX_FULL 7
`define USI_ST_RX_LVL_LSB 8

// ==========================================
// FIFO figures
`define USI_FIFO_DEPTH 4'h8
`define USI_TX_HALF 4'h4

// ==========================================
// Reset values
`define USI_IRQ_EN_RST 7'h00
`define USI_IRQ_FL_RST 7'h00
`define USI_STAT_RST 10'h014
`define USI_CTS_RST 1'h0
`define USI_TX_LVL_RST 4'h0

`endif

// file: common/usi_pkg.sv
// Types of the serial status and interrupt-enable block
`default_nettype none
package usi_pkg;

   typedef logic [6:0] usi_irq_t;
   typedef logic [3:0] usi_lvl_t;

   // Line-side receive events, one-cycle pulses
   typedef struct packed {
      logic threshold;
      logic overrun;
      logic parity_err;
      logic frame_err;
   } usi_rx_evt_s;

   // Sampled status snapshot
   typedef struct packed {
      usi_lvl_t rx_lvl;
      logic tx_full;
      logic tx_empty;
      logic rx_full;
      logic rx_empty;
      logic rx_busy;
      logic tx_busy;
   } usi_stat_s;

endpackage
`default_nettype wire

// file: rtl/usi_status_irq.sv
// Serial port status reporting, event flags and interrupt enables
`timescale 1ns/1ps
`default_nettype none
`include "usi_params.svh"

module usi_status_irq (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [3:0] rx_level_in,
   input wire logic [3:0] tx_level_in,
   input wire logic rx_busy_in,
   input wire logic tx_busy_in,
   input wire logic cts_in,
   input wire usi_pkg::usi_rx_evt_s rx_evt,
   output logic irq
);

   // ==========================================
   // Status snapshot
   usi_pkg::usi_stat_s stat_ff;
   usi_pkg::usi_stat_s nxt_stat;
   usi_pkg::usi_lvl_t rx_lvl_clip;
   usi_pkg::usi_lvl_t tx_lvl_clip;

   // Out-of-range levels from the FIFO never reach software
   usi_lvl_clip #(
      .W(4)
   ) rx_clip_u (
      .lvl_in(rx_level_in),
      .ceil_in(`USI_FIFO_DEPTH),
      .lvl_out(rx_lvl_clip)
   );

   usi_lvl_clip #(
      .W(4)
   ) tx_clip_u (
      .lvl_in(tx_level_in),
      .ceil_in(`USI_FIFO_DEPTH),
      .lvl_out(tx_lvl_clip)
   );

   always_comb begin
      nxt_stat.rx_lvl = rx_lvl_clip;
      nxt_stat.tx_full = (tx_lvl_clip == `USI_FIFO_DEPTH);
      nxt_stat.tx_empty = (tx_lvl_clip == 4'h0);
      nxt_stat.rx_full = (rx_lvl_clip == `USI_FIFO_DEPTH);
      nxt_stat.rx_empty = (rx_lvl_clip == 4'h0);
      nxt_stat.rx_busy = rx_busy_in;
      nxt_stat.tx_busy = tx_busy_in;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stat_ff <= `USI_STAT_RST;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   // ==========================================
   // Event detection from line-side history
   logic cts_ff;
   logic nxt_cts;
   usi_pkg::usi_lvl_t tx_lvl_ff;
   usi_pkg::usi_lvl_t nxt_tx_lvl;
   logic tx_half_empty_event;
   logic clear_to_send_change_event;
   usi_pkg::usi_irq_t evt_vec;

   always_comb begin
      nxt_cts = cts_in;
      nxt_tx_lvl = tx_lvl_clip;
      // Fires once as the level drops through half, not while it sits there
      tx_half_empty_event = (tx_lvl_ff > `USI_TX_HALF) &&
                            (tx_lvl_clip <= `USI_TX_HALF);
      clear_to_send_change_event = (cts_ff != cts_in);
      evt_vec = 7'h00;
      evt_vec[`USI_BIT_TX_HALF_EMPTY_EVENT] = tx_half_empty_event;
      evt_vec[`USI_BIT_RX_THD] = rx_evt.threshold;
      evt_vec[`USI_BIT_RX_OVERRUN_EVENT] = rx_evt.overrun;
      evt_vec[`USI_BIT_CLEAR_TO_SEND_CHANGE_EVENT] = clear_to_send_change_event;
      evt_vec[`USI_BIT_RX_PAR] = rx_evt.parity_err;
      evt_vec[`USI_BIT_RX_FERR] = rx_evt.frame_err;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cts_ff <= `USI_CTS_RST;
         tx_lvl_ff <= `USI_TX_LVL_RST;
      end else begin
         cts_ff <= nxt_cts;
         tx_lvl_ff <= nxt_tx_lvl;
      end
   end

   // ==========================================
   // Interrupt enable and flag registers
   usi_pkg::usi_irq_t serial_irq_enable_ff;
   usi_pkg::usi_irq_t nxt_serial_irq_enable;
   usi_pkg::usi_irq_t serial_irq_flags_ff;
   usi_pkg::usi_irq_t nxt_serial_irq_flags;
   logic wr_en_hit;
   logic wr_fl_hit;
   usi_pkg::usi_irq_t w1c_vec;

   always_comb begin
      wr_en_hit = reg_wr && (reg_addr == `USI_OFF_IRQ_EN);
      wr_fl_hit = reg_wr && (reg_addr == `USI_OFF_IRQ_FL);
      w1c_vec = 7'h00;
      if (wr_fl_hit) begin
         w1c_vec = reg_wdata[6:0] & `USI_IRQ_IMPL_MASK;
      end
      nxt_serial_irq_enable = serial_irq_enable_ff;
      if (wr_en_hit) begin
         // Reserved positions stay zero whatever is written
         nxt_serial_irq_enable = reg_wdata[6:0] &
                                 `USI_IRQ_IMPL_MASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         serial_irq_enable_ff <= `USI_IRQ_EN_RST;
         serial_irq_flags_ff <= `USI_IRQ_FL_RST;
      end else begin
         serial_irq_enable_ff <= nxt_serial_irq_enable;
         serial_irq_flags_ff <= nxt_serial_irq_flags;
      end
   end

   // ==========================================
   // Interrupt output
   usi_pkg::usi_irq_t irq_pend;

   // Position 5 is reserved: never a flag, never pending
   assign nxt_serial_irq_flags[5] = 1'b0;
   assign irq_pend[5] = 1'b0;

   usi_irq_bit #(
      .POS(`USI_BIT_TX_HALF_EMPTY_EVENT)
   ) tx_half_empty_event_bit_u (
      .flags_in(serial_irq_flags_ff),
      .enable_in(serial_irq_enable_ff),
      .evt_in(evt_vec),
      .clr_in(w1c_vec),
      .nxt_flag(nxt_serial_irq_flags[`USI_BIT_TX_HALF_EMPTY_EVENT]),
      .pend(irq_pend[`USI_BIT_TX_HALF_EMPTY_EVENT])
   );

   usi_irq_bit #(
      .POS(`USI_BIT_RX_THD)
   ) rx_thd_bit_u (
      .flags_in(serial_irq_flags_ff),
      .enable_in(serial_irq_enable_ff),
      .evt_in(evt_vec),
      .clr_in(w1c_vec),
      .nxt_flag(nxt_serial_irq_flags[`USI_BIT_RX_THD]),
      .pend(irq_pend[`USI_BIT_RX_THD])
   );

   usi_irq_bit #(
      .POS(`USI_BIT_RX_OVERRUN_EVENT)
   ) rx_overrun_event_bit_u (
      .flags_in(serial_irq_flags_ff),
      .enable_in(serial_irq_enable_ff),
      .evt_in(evt_vec),
      .clr_in(w1c_vec),
      .nxt_flag(nxt_serial_irq_flags[`USI_BIT_RX_OVERRUN_EVENT]),
      .pend(irq_pend[`USI_BIT_RX_OVERRUN_EVENT])
   );

   usi_irq_bit #(
      .POS(`USI_BIT_CLEAR_TO_SEND_CHANGE_EVENT)
   ) cts_bit_u (
      .flags_in(serial_irq_flags_ff),
      .enable_in(serial_irq_enable_ff),
      .evt_in(evt_vec),
      .clr_in(w1c_vec),
      .nxt_flag(nxt_serial_irq_flags[`USI_BIT_CLEAR_TO_SEND_CHANGE_EVENT]),
      .pend(irq_pend[`USI_BIT_CLEAR_TO_SEND_CHANGE_EVENT])
   );

   usi_irq_bit #(
      .POS(`USI_BIT_RX_PAR)
   ) rx_par_bit_u (
      .flags_in(serial_irq_flags_ff),
      .enable_in(serial_irq_enable_ff),
      .evt_in(evt_vec),
      .clr_in(w1c_vec),
      .nxt_flag(nxt_serial_irq_flags[`USI_BIT_RX_PAR]),
      .pend(irq_pend[`USI_BIT_RX_PAR])
   );

   usi_irq_bit #(
      .POS(`USI_BIT_RX_FERR)
   ) rx_ferr_bit_u (
      .flags_in(serial_irq_flags_ff),
      .enable_in(serial_irq_enable_ff),
      .evt_in(evt_vec),
      .clr_in(w1c_vec),
      .nxt_flag(nxt_serial_irq_flags[`USI_BIT_RX_FERR]),
      .pend(irq_pend[`USI_BIT_RX_FERR])
   );

   always_comb begin
      irq = |irq_pend;
   end

   // ==========================================
   // Register read port
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] stat_word;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[`USI_ST_TX_BUSY] = stat_ff.tx_busy;
      stat_word[`USI_ST_RX_BUSY] = stat_ff.rx_busy;
      stat_word[`USI_ST_RX_EMPTY] = stat_ff.rx_empty;
      stat_word[`USI_ST_RX_FULL] = stat_ff.rx_full;
      stat_word[`USI_ST_TX_EMPTY] = stat_ff.tx_empty;
      stat_word[`USI_ST_TX_FULL] = stat_ff.tx_full;
      stat_word[`USI_ST_RX_LVL_LSB +: 4] = stat_ff.rx_lvl;
      // Data stands only in the cycle after the strobe
      nxt_rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `USI_OFF_STATUS: begin
               nxt_rdata = stat_word;
            end
            `USI_OFF_IRQ_EN: begin
               nxt_rdata = {25'h0000000, serial_irq_enable_ff};
            end
            `USI_OFF_IRQ_FL: begin
               nxt_rdata = {25'h0000000, serial_irq_flags_ff};
            end
            default: begin
               nxt_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule

// ==========================================
// Level clipper, shared by both FIFO levels
module usi_lvl_clip #(
   parameter int W = 4
) (
   input wire logic [W-1:0] lvl_in,
   input wire logic [W-1:0] ceil_in,
   output logic [W-1:0] lvl_out
);
   always_comb begin
      if (lvl_in > ceil_in) begin
         lvl_out = ceil_in;
      end else begin
         lvl_out = lvl_in;
      end
   end
endmodule

// ==========================================
// One event flag with its enable gate
module usi_irq_bit #(
   parameter int POS = 0
) (
   input wire logic [6:0] flags_in,
   input wire logic [6:0] enable_in,
   input wire logic [6:0] evt_in,
   input wire logic [6:0] clr_in,
   output logic nxt_flag,
   output logic pend
);
   always_comb begin
      // Set beats clear so an event in the clearing cycle survives
      nxt_flag = (flags_in[POS] & ~clr_in[POS]) | evt_in[POS];
      pend = flags_in[POS] & enable_in[POS];
   end
endmodule
`default_nettype wire

// file: dv/usi_status_irq_props.sv
// Port assertions and bind for the serial status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "usi_params.svh"
module usi_status_irq_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [3:0] rx_level_in,
   input wire logic [3:0] tx_level_in,
   input wire logic rx_busy_in,
   input wire logic tx_busy_in,
   input wire logic cts_in,
   input wire usi_pkg::usi_rx_evt_s rx_evt,
   input wire logic irq
);
   logic [6:0] en_ff;
   logic [6:0] nxt_en;
   always_comb begin
      nxt_en = en_ff;
      if (rst) begin
         nxt_en = `USI_IRQ_EN_RST;
      end else if (reg_wr && reg_addr == `USI_OFF_IRQ_EN) begin
         nxt_en = reg_wdata[6:0] & `USI_IRQ_IMPL_MASK;
      end
   end
   always_ff @(posedge clk_sys) begin
      en_ff <= nxt_en;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Snapshot lags one edge, so skip reads just after reset
   sequence s_rd_st;
      reg_rd && reg_addr == `USI_OFF_STATUS && !$past(rst);
   endsequence
   sequence s_rd_en;
      reg_rd && reg_addr == `USI_OFF_IRQ_EN;
   endsequence
   property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
   property p_lvl; s_rd_st |=> reg_rdata[31:8] == {20'h0,
      ($past(rx_level_in, 2) > 4'h8) ? 4'h8 : $past(rx_level_in, 2)};
   endproperty
   property p_rxfe; s_rd_st |=> reg_rdata[5:4] ==
      {$past(rx_level_in, 2) >= 4'h8, $past(rx_level_in, 2) == 4'h0};
   endproperty
   property p_txfe; s_rd_st |=> reg_rdata[7:6] ==
      {$past(tx_level_in, 2) >= 4'h8, $past(tx_level_in, 2) == 4'h0};
   endproperty
   property p_busy; s_rd_st |=> reg_rdata[1:0] ==
      {$past(rx_busy_in, 2), $past(tx_busy_in, 2)}; endproperty
   property p_en; s_rd_en |=> reg_rdata == {25'h0, en_ff}; endproperty
   property p_ferr; rx_evt.frame_err && en_ff[0] && !reg_wr |=> irq;
   endproperty
   property p_ovr; rx_evt.overrun && en_ff[3] && !reg_wr |=> irq;
   endproperty
   property p_thd; rx_evt.threshold && en_ff[4] && !reg_wr |=> irq;
   endproperty
   property p_cts; $changed(cts_in) && en_ff[2] && !reg_wr |=> irq;
   endproperty
   property p_the; tx_level_in <= 4'h4 && $past(tx_level_in) > 4'h4
      && en_ff[6] && !reg_wr |=> irq; endproperty
   property p_fall; $fell(irq) |-> $past(reg_wr && (reg_addr ==
      `USI_OFF_IRQ_EN || reg_addr == `USI_OFF_IRQ_FL)); endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   a_lvl: assert property (p_lvl) else $error("rx level wrong");
   a_rxfe: assert property (p_rxfe) else $error("rx full/empty");
   a_txfe: assert property (p_txfe) else $error("tx full/empty");
   a_busy: assert property (p_busy) else $error("busy bits");
   a_en: assert property (p_en) else $error("enable readback");
   a_ferr: assert property (p_ferr) else $error("frame irq");
   a_ovr: assert property (p_ovr) else $error("overrun irq");
   a_thd: assert property (p_thd) else $error("threshold irq");
   a_cts: assert property (p_cts) else $error("cts irq");
   a_the: assert property (p_the) else $error("half-empty irq");
   a_fall: assert property (p_fall) else $error("irq dropped");
endmodule
bind usi_status_irq usi_status_irq_props chk_u (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .rx_level_in(rx_level_in), .tx_level_in(tx_level_in), .cts_in(cts_in),
   .rx_busy_in(rx_busy_in), .tx_busy_in(tx_busy_in), .rx_evt(rx_evt));
`default_nettype wire

// file: dv/usi_line_model.sv
// Line-side partner: FIFO levels, activity, clear-to-send, event pulses
`timescale 1ns/1ps
`default_nettype none
module usi_line_model (
   input wire logic clk_sys,
   output var logic [10:0] line,
   output var usi_pkg::usi_rx_evt_s evt
);
   initial begin
      line = 11'h0;
      evt = '0;
   end
   // Packed as rx level, tx level, rx busy, tx busy, cts
   task automatic set_line(input logic [10:0] v);
      @(posedge clk_sys);
      line <= v;
      @(posedge clk_sys);
   endtask
   task automatic pulse(input logic [3:0] b);
      @(posedge clk_sys);
      evt <= b;
      @(posedge clk_sys);
      evt <= '0;
   endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench of the serial status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "usi_params.svh"
module tb;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic rd_seen = 1'b0, irq;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, m, seed = 32'd35236;
   logic [10:0] line;
   logic [3:0] rl, tl;
   usi_pkg::usi_rx_evt_s evt;
   logic [31:0] exp_q[$];
   int fails = 0, tests_run = 0;
   int bits[6] = '{0, 1, 2, 3, 4, 6};
   always #5 clk_sys = ~clk_sys;
   usi_status_irq dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_level_in(line[10:7]),
      .tx_level_in(line[6:3]), .rx_busy_in(line[2]), .tx_busy_in(line[1]),
      .cts_in(line[0]), .rx_evt(evt), .irq(irq));
   usi_line_model line_u (.clk_sys(clk_sys), .line(line), .evt(evt));
   // ==========================================
   // Shared tasks
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input bit w);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      if (!w) exp_q.push_back(d);
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   task automatic fire(input int b);
      if (b == 2) line_u.set_line({8'h08, 2'b00, ~line[0]});
      else if (b == 6) begin
         line_u.set_line(11'h020);
         line_u.set_line(11'h040);
      end else line_u.pulse(4'h1 << (b < 2 ? b : b - 1));
   endtask
   task automatic irq_is(input logic e);
      @(negedge clk_sys);
      chk({31'h0, irq}, {31'h0, e}, "irq");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (rd_seen) chk(reg_rdata, exp_q.pop_front(), "rdata");
      rd_seen <= reg_rd;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      summarize();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      bus(`USI_OFF_STATUS, 32'h50, 0);
      bus(`USI_OFF_IRQ_EN, 32'h0, 0);
      bus(8'h10, 32'h0, 0);
      bus(`USI_OFF_IRQ_EN, 32'hffffffff, 1);
      bus(`USI_OFF_IRQ_EN, 32'h5f, 0);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         line_u.set_line(seed[10:0]);
         rl = seed[10:7] > 4'h8 ? 4'h8 : seed[10:7];
         tl = seed[6:3] > 4'h8 ? 4'h8 : seed[6:3];
         bus(`USI_OFF_STATUS, {20'h0, rl, tl == 4'h8, tl == 4'h0, rl == 4'h8,
            rl == 4'h0, 2'b00, seed[2:1]}, 0);
      end
      line_u.set_line(11'h040);
      bus(`USI_OFF_IRQ_FL, 32'h7f, 1);
      foreach (bits[k]) begin
         m = 32'h1 << bits[k];
         bus(`USI_OFF_IRQ_EN, 32'h5f & ~m, 1);
         fire(bits[k]);
         irq_is(1'b0);
         bus(`USI_OFF_IRQ_FL, m, 0);
         bus(`USI_OFF_IRQ_EN, 32'h5f, 1);
         irq_is(1'b1);
         bus(`USI_OFF_IRQ_FL, m, 1);
         irq_is(1'b0);
         fire(bits[k]);
         irq_is(1'b1);
         bus(`USI_OFF_IRQ_FL, m, 1);
      end
      irq_is(1'b0);
      summarize();
   end
endmodule
`default_nettype wire
